// ### asl_serial_port.v
// Contract
// [RULE1] connect or listen connects at once, silently
// [RULE2] connected indication follows every connect or listen; code raises it only for one taken while idle on the local port
// [RULE3] only one connection held at a time
// [RULE4] connect uses local port, ignores other arguments
// [RULE5] listen records requester id and local port
// [RULE6] connected carries upper port id only
// [RULE7] send length counts encoded characters with escapes
// [RULE8] received returns same buffer, count within maximum
// [RULE9] accepted send characters still go after disconnect
// [RULE10] link characters after disconnect may be dropped
// [RULE11] keep serving receives until received data drained
// [RULE12] disconnected once all received characters delivered
// [RULE13] disconnected reason: requested or sense deasserted
// [RULE14] automation side issues reset naming both ports
// [RULE15] reset received handled as logout or hard reset
// [RULE16] reset received names upper and local port
// [RULE17] requester retries after refused or resource errors
// [RULE18] requester reconnects or waits per error response
// [RULE19] automation reset asserts reset line toward drive
// [RULE20] sense falling may raise disconnected indication
// [RULE21] second receive before received gets pending response
// [RULE22] one-cycle request strobes, response codes, indication strobes
`include "asl_map.vh"
`timescale 1ns/1ps
`default_nettype none

module asl_serial_port #(
   parameter PORT_W = 4,
   parameter BUF_W = 8,
   parameter LEN_W = 8,
   parameter CHAR_W = 8,
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW = 5,
   parameter LOCAL_PORT_ID = 4'h0,
   parameter IS_AUTOMATION = 1'b0
) (
   input wire mclk_in,
   input wire resetn_in,
   // upper port requests
   input wire connect_req_in,
   input wire listen_req_in,
   input wire [PORT_W-1:0] req_adt_port_in,
   input wire [PORT_W-1:0] req_local_port_in,
   input wire [PORT_W-1:0] req_remote_port_in,
   input wire send_req_in,
   input wire [LEN_W-1:0] send_len_in,
   input wire [CHAR_W-1:0] send_char_in,
   input wire send_char_valid_in,
   output reg send_char_ready_out,
   input wire recv_req_in,
   input wire [BUF_W-1:0] recv_buf_in,
   input wire [LEN_W-1:0] recv_max_in,
   input wire disconnect_req_in,
   input wire [3:0] req_conn_in,
   input wire reset_req_in,
   input wire reset_mode_in,
   // responses
   output reg rsp_valid_out,
   output reg [2:0] rsp_code_out,
   // indications
   output reg connected_out,
   output reg [PORT_W-1:0] ind_adt_port_out,
   output reg [PORT_W-1:0] ind_local_port_out,
   output reg [3:0] ind_conn_out,
   output reg received_out,
   output reg [BUF_W-1:0] recvd_buf_out,
   output reg [LEN_W-1:0] recvd_count_out,
   output reg recvd_char_valid_out,
   output reg [CHAR_W-1:0] recvd_char_out,
   output reg disconnected_out,
   output reg [1:0] disc_reason_out,
   output reg reset_received_out,
   output reg reset_hard_out,
   // physical side
   output reg [CHAR_W-1:0] tx_char_out,
   output reg tx_valid_out,
   input wire tx_ready_in,
   input wire [CHAR_W-1:0] rx_char_in,
   input wire rx_valid_in,
   input wire sense_in,
   input wire reset_line_in,
   output reg reset_line_out
);

////////////////////////////////////////////////////////////////////////////////

   localparam ST_IDLE = 2'h0;
   localparam ST_OPEN = 2'h1;
   localparam ST_DRAIN = 2'h2;
   localparam [31:0] HOLD_FULL = `ASL_RST_HOLD_CYC;
   localparam [7:0] HOLD_CYC = HOLD_FULL[7:0];

   reg [1:0] state_reg;
   reg [LEN_W-1:0] send_left_reg;
   reg recv_busy_reg;
   reg [BUF_W-1:0] recv_buf_reg;
   reg [LEN_W-1:0] recv_max_reg;
   reg [LEN_W-1:0] recv_cnt_reg;
   reg [1:0] why_reg;
   reg sense_q_reg;
   reg rstl_q_reg;
   reg [7:0] hold_reg;

   wire [CHAR_W-1:0] txf_data;
   wire txf_valid;
   wire txf_wready;
   wire [FIFO_AW:0] txf_count;
   wire [CHAR_W-1:0] rxf_data;
   wire rxf_valid;
   wire rxf_wready;
   wire [FIFO_AW:0] rxf_count;
   wire rx_pop;
   wire tx_pop;
   wire rx_accept;
   wire sense_fall;
   wire local_hit;
   wire conn_ok;

   function [LEN_W:0] widen;
      input [LEN_W-1:0] v;
      widen = {1'b0, v};
   endfunction

   assign local_hit = (req_local_port_in == LOCAL_PORT_ID[PORT_W-1:0]);
   assign conn_ok = (state_reg == ST_OPEN) && (req_conn_in == `ASL_CONN_ID);
   assign sense_fall = sense_q_reg & ~sense_in;
   // link characters are kept only while open; after disconnect they drop
   assign rx_accept = rx_valid_in && (state_reg == ST_OPEN); // [RULE10]
   // drain received characters one per cycle into the open receive buffer
   assign rx_pop = recv_busy_reg && rxf_valid && (recv_cnt_reg != recv_max_reg); // [RULE8]
   assign tx_pop = txf_valid && (!tx_valid_out || tx_ready_in);

////////////////////////////////////////////////////////////////////////////////

   asl_fifo #(
      .WIDTH(CHAR_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_txf (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .clear_in(reset_line_in & ~IS_AUTOMATION),
      .wr_data_in(send_char_in),
      .wr_valid_in(send_char_valid_in && send_char_ready_out),
      .wr_ready_out(txf_wready),
      .rd_data_out(txf_data),
      .rd_valid_out(txf_valid),
      .rd_ready_in(tx_pop),
      .count_out(txf_count)
   );

   asl_fifo #(
      .WIDTH(CHAR_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_rxf (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .clear_in(state_reg == ST_IDLE),
      .wr_data_in(rx_char_in),
      .wr_valid_in(rx_accept),
      .wr_ready_out(rxf_wready),
      .rd_data_out(rxf_data),
      .rd_valid_out(rxf_valid),
      .rd_ready_in(rx_pop),
      .count_out(rxf_count)
   );

////////////////////////////////////////////////////////////////////////////////
// transmit side keeps running regardless of connection state, so accepted
// characters still leave after a disconnect

   always @(posedge mclk_in) begin
      if (!resetn_in) begin
         tx_valid_out <= 1'b0;
         tx_char_out <= {CHAR_W{1'b0}};
      end else if (tx_pop) begin
         tx_valid_out <= 1'b1; // [RULE9]
         tx_char_out <= txf_data;
      end else if (tx_ready_in) begin
         tx_valid_out <= 1'b0;
      end
   end

////////////////////////////////////////////////////////////////////////////////

   always @(posedge mclk_in) begin
      if (!resetn_in) begin
         state_reg <= ST_IDLE;
         send_left_reg <= {LEN_W{1'b0}};
         send_char_ready_out <= 1'b0;
         recv_busy_reg <= 1'b0;
         recv_buf_reg <= {BUF_W{1'b0}};
         recv_max_reg <= {LEN_W{1'b0}};
         recv_cnt_reg <= {LEN_W{1'b0}};
         why_reg <= `ASL_WHY_REQUESTED;
         sense_q_reg <= 1'b0;
         rstl_q_reg <= 1'b0;
         hold_reg <= 8'h00;
         rsp_valid_out <= 1'b0;
         rsp_code_out <= `ASL_RSP_GOOD;
         connected_out <= 1'b0;
         ind_adt_port_out <= {PORT_W{1'b0}};
         ind_local_port_out <= {PORT_W{1'b0}};
         ind_conn_out <= 4'h0;
         received_out <= 1'b0;
         recvd_buf_out <= {BUF_W{1'b0}};
         recvd_count_out <= {LEN_W{1'b0}};
         recvd_char_valid_out <= 1'b0;
         recvd_char_out <= {CHAR_W{1'b0}};
         disconnected_out <= 1'b0;
         disc_reason_out <= `ASL_WHY_REQUESTED;
         reset_received_out <= 1'b0;
         reset_hard_out <= 1'b0;
         reset_line_out <= 1'b0;
      end else begin
         // indications and responses are one-cycle strobes by default
         rsp_valid_out <= 1'b0; // [RULE22]
         connected_out <= 1'b0;
         received_out <= 1'b0;
         disconnected_out <= 1'b0;
         reset_received_out <= 1'b0;
         recvd_char_valid_out <= 1'b0;
         sense_q_reg <= sense_in;
         rstl_q_reg <= reset_line_in;

         // send payload: the stated length is already encoded, escapes included
         if (send_char_ready_out && send_char_valid_in) begin
            send_left_reg <= send_left_reg - 1'b1; // [RULE7]
            if (send_left_reg == {{(LEN_W-1){1'b0}}, 1'b1}) begin
               send_char_ready_out <= 1'b0;
            end
         end

         if (rx_pop) begin
            recvd_char_valid_out <= 1'b1;
            recvd_char_out <= rxf_data;
            recv_cnt_reg <= recv_cnt_reg + 1'b1;
         end

         // close the pending receive once it holds a character and the buffer is full or no data is left buffered
         if (recv_busy_reg && recv_cnt_reg != {LEN_W{1'b0}} && !rx_pop) begin
            received_out <= 1'b1;
            recvd_buf_out <= recv_buf_reg; // [RULE8]
            recvd_count_out <= recv_cnt_reg;
            ind_conn_out <= `ASL_CONN_ID;
            recv_busy_reg <= 1'b0;
         end

         case (state_reg)
            ST_IDLE: begin
               if ((connect_req_in || listen_req_in) && local_hit) begin
                  // established at once; nothing goes out on the link
                  state_reg <= ST_OPEN; // [RULE1]
                  connected_out <= 1'b1; // [RULE2]
                  // connect ignores requester and remote port, listen keeps requester
                  ind_adt_port_out <= listen_req_in ? req_adt_port_in : {PORT_W{1'b0}}; // [RULE4] [RULE5]
                  ind_local_port_out <= req_local_port_in;
                  ind_conn_out <= 4'h0; // [RULE6]
                  rsp_valid_out <= 1'b1;
                  rsp_code_out <= sense_in ? `ASL_RSP_GOOD : `ASL_RSP_NO_PHYS;
               end
            end
            ST_OPEN: begin
               if (sense_fall) begin
                  state_reg <= ST_DRAIN; // [RULE20]
                  why_reg <= `ASL_WHY_SENSE; // [RULE13]
               end else if (disconnect_req_in) begin
                  rsp_valid_out <= 1'b1;
                  if (req_conn_in == `ASL_CONN_ID) begin
                     state_reg <= ST_DRAIN;
                     why_reg <= `ASL_WHY_REQUESTED; // [RULE13]
                     rsp_code_out <= `ASL_RSP_GOOD;
                  end else begin
                     rsp_code_out <= `ASL_RSP_INVALID_CONN;
                  end
               end
            end
            ST_DRAIN: begin
               // disconnected only after every received character went upward
               if (!rxf_valid && !recv_busy_reg && !rx_pop) begin
                  state_reg <= ST_IDLE; // [RULE12]
                  disconnected_out <= 1'b1;
                  disc_reason_out <= why_reg;
                  ind_conn_out <= `ASL_CONN_ID;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase

         // a second connect while one is held is refused
         if ((connect_req_in || listen_req_in) && (state_reg != ST_IDLE || !local_hit)) begin
            rsp_valid_out <= 1'b1; // [RULE3]
            rsp_code_out <= local_hit ? `ASL_RSP_REFUSED : `ASL_RSP_INVALID_REMOTE;
         end

         if (send_req_in) begin
            rsp_valid_out <= 1'b1;
            if (!conn_ok) begin
               rsp_code_out <= `ASL_RSP_INVALID_CONN;
            end else if (send_char_ready_out ||
                         widen(send_len_in) + txf_count > FIFO_DEPTH) begin
               rsp_code_out <= `ASL_RSP_OUT_OF_RES;
            end else begin
               rsp_code_out <= `ASL_RSP_GOOD;
               send_left_reg <= send_len_in;
               send_char_ready_out <= (send_len_in != {LEN_W{1'b0}});
            end
         end

         if (recv_req_in) begin
            rsp_valid_out <= 1'b1;
            // receives stay legal while draining after a disconnect
            if (state_reg == ST_IDLE || req_conn_in != `ASL_CONN_ID) begin
               rsp_code_out <= `ASL_RSP_INVALID_CONN;
            end else if (recv_busy_reg || recv_max_in == {LEN_W{1'b0}}) begin
               rsp_code_out <= `ASL_RSP_RECV_PENDING; // [RULE21]
            end else begin
               rsp_code_out <= `ASL_RSP_GOOD; // [RULE11]
               recv_busy_reg <= 1'b1;
               recv_buf_reg <= recv_buf_in;
               recv_max_reg <= recv_max_in;
               recv_cnt_reg <= {LEN_W{1'b0}};
            end
         end

         // automation end: assert the reset line toward the drive for a hold time
         if (IS_AUTOMATION && reset_req_in && local_hit) begin
            hold_reg <= HOLD_CYC; // [RULE19]
            reset_line_out <= 1'b1;
            state_reg <= ST_IDLE;
            send_char_ready_out <= 1'b0;
            recv_busy_reg <= 1'b0;
         end else if (hold_reg != 8'h00) begin
            hold_reg <= hold_reg - 1'b1;
            reset_line_out <= (hold_reg != 8'h01);
         end

         // drive end: rising reset line drops the connection
         if (!IS_AUTOMATION && reset_line_in && !rstl_q_reg) begin
            reset_received_out <= 1'b1;
            reset_hard_out <= reset_mode_in; // [RULE15]
            ind_adt_port_out <= req_adt_port_in; // [RULE16]
            ind_local_port_out <= LOCAL_PORT_ID[PORT_W-1:0];
            state_reg <= ST_IDLE;
            send_char_ready_out <= 1'b0;
            recv_busy_reg <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// ### asl_map.vh
`ifndef ASL_MAP_VH
`define ASL_MAP_VH

// service response codes
`define ASL_RSP_GOOD 3'h0
`define ASL_RSP_INVALID_CONN 3'h1
`define ASL_RSP_RECV_PENDING 3'h2
`define ASL_RSP_OUT_OF_RES 3'h3
`define ASL_RSP_NO_PHYS 3'h4
`define ASL_RSP_REFUSED 3'h5
`define ASL_RSP_INVALID_REMOTE 3'h6

// disconnected reason codes
`define ASL_WHY_REQUESTED 2'h0
`define ASL_WHY_SENSE 2'h1

// reset handling mode on the tape_drive_side
`define ASL_RST_LOGOUT 1'h0
`define ASL_RST_HARD 1'h1

// reset line hold toward the drive, in ns, and as a cycle count at 20 MHz
`define ASL_CLK_NS 50
`define ASL_RST_HOLD_NS 1000
`define ASL_RST_HOLD_CYC ((`ASL_RST_HOLD_NS + `ASL_CLK_NS - 1) / `ASL_CLK_NS)

// fixed connection identifier, the single serial connection
`define ASL_CONN_ID 4'h1

`endif

// ### asl_fifo.v
`timescale 1ns/1ps
`default_nettype none

module asl_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire mclk_in,
   input wire resetn_in,
   input wire clear_in,
   input wire [WIDTH-1:0] wr_data_in,
   input wire wr_valid_in,
   output wire wr_ready_out,
   output wire [WIDTH-1:0] rd_data_out,
   output wire rd_valid_out,
   input wire rd_ready_in,
   output wire [AW:0] count_out
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wp_reg;
   reg [AW-1:0] rp_reg;
   reg [AW:0] cnt_reg;
   wire do_wr;
   wire do_rd;

   assign wr_ready_out = (cnt_reg != DEPTH[AW:0]);
   assign rd_valid_out = (cnt_reg != {(AW+1){1'b0}});
   assign rd_data_out = mem[rp_reg];
   assign count_out = cnt_reg;
   assign do_wr = wr_valid_in & wr_ready_out;
   assign do_rd = rd_ready_in & rd_valid_out;

   always @(posedge mclk_in) begin
      if (do_wr) begin
         mem[wp_reg] <= wr_data_in;
      end
   end

   always @(posedge mclk_in) begin
      if (!resetn_in || clear_in) begin
         wp_reg <= {AW{1'b0}};
         rp_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wp_reg <= (wp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_reg + 1'b1;
         end
         if (do_rd) begin
            rp_reg <= (rp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_reg + 1'b1;
         end
         case ({do_wr, do_rd})
            2'b10: cnt_reg <= cnt_reg + 1'b1;
            2'b01: cnt_reg <= cnt_reg - 1'b1;
            default: cnt_reg <= cnt_reg;
         endcase
      end
   end
endmodule

`default_nettype wire

// ### asl_serial_port_sva.sv
`include "asl_map.vh"
`timescale 1ns/1ps
`default_nettype none
module asl_chk #(
   parameter BUF_W = 8,
   parameter LEN_W = 8
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic connect_req_in,
   input wire logic listen_req_in,
   input wire logic send_req_in,
   input wire logic recv_req_in,
   input wire logic [BUF_W-1:0] recv_buf_in,
   input wire logic [LEN_W-1:0] recv_max_in,
   input wire logic disconnect_req_in,
   input wire logic [3:0] req_conn_in,
   input wire logic rsp_valid_out,
   input wire logic [2:0] rsp_code_out,
   input wire logic connected_out,
   input wire logic received_out,
   input wire logic [BUF_W-1:0] recvd_buf_out,
   input wire logic [LEN_W-1:0] recvd_count_out,
   input wire logic recvd_char_valid_out,
   input wire logic disconnected_out,
   input wire logic [1:0] disc_reason_out,
   input wire logic reset_line_in,
   input wire logic reset_received_out,
   input wire logic tx_valid_out
);
   logic last_recv_reg, open_reg, disc_reg;
   logic [BUF_W-1:0] buf_reg, acc_buf_reg;
   logic [LEN_W-1:0] max_reg, acc_max_reg, n_reg;
   wire logic any_req = connect_req_in | listen_req_in | send_req_in | recv_req_in |
      disconnect_req_in;
   wire logic good = rsp_valid_out && rsp_code_out == `ASL_RSP_GOOD;
   // a receive is outstanding from its good response until received
   wire logic busy = (open_reg || last_recv_reg && good) && !received_out;
   ////////////////////////////////////////
   always @(posedge mclk_in) begin
      last_recv_reg <= recv_req_in && resetn_in;
      if (recv_req_in) begin
         buf_reg <= recv_buf_in;
         max_reg <= recv_max_in;
      end
      if (recvd_char_valid_out) n_reg <= n_reg + 1'b1;
      if (!resetn_in || received_out) open_reg <= 1'b0;
      if (last_recv_reg && good) begin
         open_reg <= 1'b1;
         acc_buf_reg <= buf_reg;
         acc_max_reg <= max_reg;
         n_reg <= '0;
      end
      if (!resetn_in || disconnected_out || connected_out) disc_reg <= 1'b0;
      else if (disconnect_req_in && req_conn_in == `ASL_CONN_ID) disc_reg <= 1'b1;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);
   sequence s_open;
      connect_req_in || listen_req_in;
   endsequence
   sequence s_good;
      rsp_valid_out && rsp_code_out == `ASL_RSP_GOOD;
   endsequence
   AST_CONN_IND: assert property (s_open ##1 s_good |-> connected_out)
      else $error("no connected strobe");
   AST_SILENT: assert property (s_open ##1 s_good |-> !tx_valid_out)
      else $error("link transmit on open");
   AST_RSP: assert property (any_req |=> rsp_valid_out)
      else $error("request without response");
   AST_RSP_CAUSE: assert property (rsp_valid_out |-> $past(any_req))
      else $error("response without request");
   AST_PENDING: assert property (recv_req_in && busy |=> rsp_code_out == 3'h2)
      else $error("second receive not refused");
   AST_RECV_BUF: assert property (received_out |-> recvd_buf_out == acc_buf_reg)
      else $error("received names another buffer");
   AST_RECV_CNT: assert property (received_out |-> recvd_count_out == n_reg &&
      n_reg <= acc_max_reg) else $error("received count wrong");
   AST_DRAINED: assert property (disconnected_out |-> !busy)
      else $error("disconnected with receive open");
   AST_REASON: assert property (disconnected_out |-> disc_reason_out == (disc_reg ?
      `ASL_WHY_REQUESTED : `ASL_WHY_SENSE)) else $error("disconnected reason wrong");
   AST_RST_IND: assert property ($rose(reset_line_in) |-> ##[0:8] reset_received_out)
      else $error("no reset received");
endmodule
bind asl_serial_port asl_chk #(.BUF_W(BUF_W), .LEN_W(LEN_W)) u_chk (
   .mclk_in, .resetn_in, .connect_req_in, .listen_req_in, .send_req_in, .recv_req_in,
   .recv_buf_in, .recv_max_in, .disconnect_req_in, .req_conn_in, .rsp_valid_out,
   .rsp_code_out, .connected_out, .received_out, .recvd_buf_out, .recvd_count_out,
   .recvd_char_valid_out, .disconnected_out, .disc_reason_out, .reset_line_in,
   .reset_received_out, .tx_valid_out
);
`default_nettype wire

// ### asl_link_peer.sv
`timescale 1ns/1ps
`default_nettype none
module asl_link_peer (
   input wire logic mclk_in,
   input wire logic [7:0] tx_char_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   output logic [7:0] rx_char_out,
   output logic rx_valid_out,
   output logic sense_out,
   output logic reset_line_out,
   input wire logic stall_in
);
   logic [7:0] cap [0:15];
   int cap_n = 0;
   logic [1:0] slow_reg = 2'h0;
   initial begin
      rx_char_out = 8'h00;
      rx_valid_out = 1'b0;
      sense_out = 1'b0;
      reset_line_out = 1'b0;
   end
   // stalled: one character in four, so queued sends outlive a close
   assign tx_ready_out = !stall_in || slow_reg == 2'h3;
   always @(posedge mclk_in) begin
      slow_reg <= slow_reg + 2'h1;
      if (tx_valid_in && tx_ready_out && cap_n < 16) begin
         cap[cap_n] <= tx_char_in;
         cap_n <= cap_n + 1;
      end
   end
   ////////////////////////////////////////
   task automatic push_rx(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk_in);
         rx_valid_out <= 1'b1;
         rx_char_out <= base + 8'(i);
      end
      @(posedge mclk_in);
      rx_valid_out <= 1'b0;
      // released data shows the inverse
      rx_char_out <= ~rx_char_out;
   endtask
   task automatic set_sense(input logic v);
      @(posedge mclk_in);
      sense_out <= v;
   endtask
   task automatic set_line(input logic v);
      @(posedge mclk_in);
      reset_line_out <= v;
   endtask
endmodule
`default_nettype wire

// ### asl_serial_port_tb.sv
`include "asl_map.vh"
`timescale 1ns/1ps
`default_nettype none
module asl_serial_port_tb;
   logic mclk_in, resetn_in, connect_req_in, listen_req_in, send_req_in, recv_req_in;
   logic disconnect_req_in, send_char_valid_in, send_char_ready_out, reset_req_in;
   logic reset_mode_in, rsp_valid_out, connected_out, received_out, recvd_char_valid_out;
   logic disconnected_out, reset_received_out, reset_hard_out, tx_valid_out, tx_ready_in;
   logic rx_valid_in, sense_in, reset_line_in, reset_line_out, stall, saw_recv;
   logic [3:0] req_adt_port_in, req_local_port_in, req_remote_port_in, req_conn_in;
   logic [3:0] ind_adt_port_out, ind_local_port_out, ind_conn_out;
   logic [7:0] send_len_in, send_char_in, recv_buf_in, recv_max_in, recvd_buf_out;
   logic [7:0] recvd_count_out, recvd_char_out, tx_char_out, rx_char_in;
   logic [7:0] rxq [0:15];
   logic [2:0] rsp_code_out;
   logic [1:0] disc_reason_out;
   int err_count = 0;
   int n_checks = 0;
   int nrx;
   asl_serial_port DUT (
      .mclk_in, .resetn_in, .connect_req_in, .listen_req_in, .req_adt_port_in,
      .req_local_port_in, .req_remote_port_in, .send_req_in, .send_len_in, .send_char_in,
      .send_char_valid_in, .send_char_ready_out, .recv_req_in, .recv_buf_in, .recv_max_in,
      .disconnect_req_in, .req_conn_in, .reset_req_in, .reset_mode_in, .rsp_valid_out,
      .rsp_code_out, .connected_out, .ind_adt_port_out, .ind_local_port_out, .ind_conn_out,
      .received_out, .recvd_buf_out, .recvd_count_out, .recvd_char_valid_out,
      .recvd_char_out, .disconnected_out, .disc_reason_out, .reset_received_out,
      .reset_hard_out, .tx_char_out, .tx_valid_out, .tx_ready_in, .rx_char_in, .rx_valid_in,
      .sense_in, .reset_line_in, .reset_line_out
   );
   asl_link_peer peer (
      .mclk_in, .tx_char_in(tx_char_out), .tx_valid_in(tx_valid_out),
      .tx_ready_out(tx_ready_in), .rx_char_out(rx_char_in), .rx_valid_out(rx_valid_in),
      .sense_out(sense_in), .reset_line_out(reset_line_in), .stall_in(stall)
   );
   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end
   ////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic grab;
      if (recvd_char_valid_out === 1'b1 && nrx < 16) begin
         rxq[nrx] = recvd_char_out;
         nrx++;
      end
      if (received_out === 1'b1) saw_recv = 1'b1;
   endtask
   task automatic wait_ind(input int k);
      logic hit;
      for (int i = 0; i < 200; i++) begin
         @(posedge mclk_in);
         #1;
         grab();
         hit = k == 0 ? received_out : k == 1 ? disconnected_out : reset_received_out;
         if (hit === 1'b1) return;
      end
      err_count++;
      conclude();
   endtask
   // k: 0 connect, 1 listen, 2 send, 3 receive, 4 disconnect
   task automatic req(input int k, input logic [3:0] lp, input logic [3:0] ap,
         input logic [3:0] cn, input logic [7:0] ln, input logic [7:0] bf, input logic [2:0] ex);
      @(posedge mclk_in);
      {connect_req_in, listen_req_in, send_req_in} <= {k == 0, k == 1, k == 2};
      {recv_req_in, disconnect_req_in} <= {k == 3, k == 4};
      {req_local_port_in, req_adt_port_in, req_remote_port_in, req_conn_in} <= {lp, ap, ~lp, cn};
      {send_len_in, recv_max_in, recv_buf_in} <= {ln, ln, bf};
      @(posedge mclk_in);
      {connect_req_in, listen_req_in, send_req_in, recv_req_in, disconnect_req_in} <= 5'h00;
      #1;
      check(rsp_valid_out, 1'b1);
      check(rsp_code_out, ex);
   endtask
   task automatic push_tx(input int n, input logic [7:0] base);
      int j;
      @(posedge mclk_in);
      for (int i = 0; i < n; i++) begin
         send_char_valid_in <= 1'b1;
         send_char_in <= base + 8'(i);
         j = 0;
         do begin
            @(posedge mclk_in);
            j++;
         end while (send_char_ready_out !== 1'b1 && j < 50);
      end
      send_char_valid_in <= 1'b0;
   endtask
   ////////////////////////////////////////
   task automatic t_open;
      req(0, 4'h3, 4'h9, 4'h1, 8'h00, 8'h00, `ASL_RSP_INVALID_REMOTE);
      req(0, 4'h0, 4'h9, 4'h1, 8'h00, 8'h00, `ASL_RSP_GOOD);
      check(connected_out, 1'b1);
      check(tx_valid_out, 1'b0);
      req(0, 4'h0, 4'h9, 4'h1, 8'h00, 8'h00, `ASL_RSP_REFUSED);
   endtask
   task automatic t_recv;
      nrx = 0;
      peer.push_rx(3, 8'h40);
      @(posedge mclk_in);
      {recv_req_in, recv_buf_in, recv_max_in, req_conn_in} <= {1'b1, 8'h5A, 8'h02, 4'h1};
      @(posedge mclk_in);
      #1;
      check(rsp_code_out, `ASL_RSP_GOOD);
      grab();
      @(posedge mclk_in);
      recv_req_in <= 1'b0;
      #1;
      check(rsp_code_out, `ASL_RSP_RECV_PENDING);
      grab();
      wait_ind(0);
      check(recvd_buf_out, 8'h5A);
      check(recvd_count_out, 8'h02);
      check({ind_conn_out, rxq[0], rxq[1]}, 20'h14041);
   endtask
   task automatic t_close;
      nrx = 0;
      saw_recv = 1'b0;
      stall <= 1'b1;
      req(2, 4'h0, 4'h0, 4'h1, 8'h04, 8'h00, `ASL_RSP_GOOD);
      req(2, 4'h0, 4'h0, 4'h1, 8'h04, 8'h00, `ASL_RSP_OUT_OF_RES);
      push_tx(4, 8'hC0);
      req(4, 4'h0, 4'h9, 4'h2, 8'h00, 8'h00, `ASL_RSP_INVALID_CONN);
      req(4, 4'h0, 4'h9, 4'h1, 8'h00, 8'h00, `ASL_RSP_GOOD);
      req(3, 4'h0, 4'h0, 4'h1, 8'h08, 8'h33, `ASL_RSP_GOOD);
      wait_ind(1);
      check(saw_recv, 1'b1);
      check(rxq[0], 8'h42);
      check(disc_reason_out, `ASL_WHY_REQUESTED);
      for (int i = 0; i < 300 && peer.cap_n < 4; i++) @(posedge mclk_in);
      check({peer.cap[0], peer.cap[1], peer.cap[2], peer.cap[3]}, 32'hC0C1C2C3);
      stall <= 1'b0;
      req(3, 4'h0, 4'h0, 4'h1, 8'h08, 8'h33, `ASL_RSP_INVALID_CONN);
   endtask
   task automatic t_sense;
      req(1, 4'h0, 4'h6, 4'h0, 8'h00, 8'h00, `ASL_RSP_GOOD);
      check(connected_out, 1'b1);
      check(ind_adt_port_out, 4'h6);
      peer.set_sense(1'b0);
      wait_ind(1);
      check(disc_reason_out, `ASL_WHY_SENSE);
      peer.set_sense(1'b1);
   endtask
   task automatic t_reset;
      for (int m = 0; m < 2; m++) begin
         @(posedge mclk_in);
         reset_mode_in <= m[0];
         peer.set_line(1'b1);
         wait_ind(2);
         check(reset_hard_out, m[0]);
         check(ind_local_port_out, 4'h0);
         repeat (20) @(posedge mclk_in);
         peer.set_line(1'b0);
         repeat (4) @(posedge mclk_in);
      end
   endtask
   ////////////////////////////////////////
   initial begin
      {connect_req_in, listen_req_in, send_req_in, recv_req_in, disconnect_req_in} = 5'h00;
      {send_char_valid_in, reset_req_in, reset_mode_in, stall, resetn_in} = 5'h00;
      {req_adt_port_in, req_local_port_in, req_remote_port_in, req_conn_in} = 16'h0000;
      {send_len_in, send_char_in, recv_buf_in, recv_max_in} = 32'h00000000;
      peer.set_sense(1'b1);
      repeat (2) @(posedge mclk_in);
      resetn_in <= 1'b1;
      t_open();
      t_recv();
      t_close();
      t_sense();
      t_reset();
      conclude();
   end
endmodule
`default_nettype wire
